/* File: hw/rlwc_top.sv */
// read parameter and burst wrap configuration loaded over the serial pins
`timescale 1ns/1ns
`default_nettype none
`include "rlwc_defs.svh"

module rlwc_top import rlwc_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  // device mode and reset request
  input wire logic four_wire_command_mode,
  input wire logic four_byte_addr,
  input wire logic soft_reset,
  // read query from the read path
  input wire logic [7:0] rd_opcode,
  input wire logic [31:0] rd_addr,
  // read answer
  output logic [4:0] rd_dummy,
  output logic rd_mode_in_dummy,
  output logic rd_configurable,
  output logic rd_wrap_en,
  output logic [6:0] rd_wrap_bytes,
  output logic [31:0] rd_next_addr,
  // stored state
  output logic [7:0] read_parameter,
  output logic [2:0] spi_burst_bits
);

  // reset release through two flops
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // pin synchronisers; the extra clock stage only feeds edge detection
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic sclk_last;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // idle levels: clock low, chip select high, so no false frame after reset
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
      sclk_last <= 1'b0;
    end else begin
      pin_meta <= {sclk, io_in, ~cs_n};
      pin_sync <= pin_meta;
      sclk_last <= pin_sync[5];
    end
  end

  logic sel;
  logic [3:0] io_s;
  logic sclk_rise;

  // frame active and rising serial clock seen at sys_clk rate
  // each sclk level must last a few sys_clk periods or its edge is lost
  assign sel = pin_sync[0];
  assign io_s = pin_sync[4:1];
  assign sclk_rise = pin_sync[5] && !sclk_last;

  // decoder and configuration state
  rlwc_state_t state;
  rlwc_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic qpi_cmd;
  logic next_qpi_cmd;
  logic kind_burst;
  logic next_kind_burst;
  logic pend;
  logic next_pend;
  logic [7:0] pend_val;
  logic [7:0] next_pend_val;
  rlwc_cfg_t cfg;
  rlwc_cfg_t next_cfg;

  // shift value for the current lane width
  function automatic logic [7:0] rlwc_shift(input logic [7:0] s, input logic [3:0] io, input logic wide);
    rlwc_shift = wide ? {s[3:0], io} : {s[6:0], io[0]};
  endfunction

  // last edge index of one byte for the lane width
  function automatic logic [3:0] rlwc_last(input logic wide);
    rlwc_last = wide ? `RLWC_OP_EDGES_QPI : `RLWC_OP_EDGES_SPI;
  endfunction

  logic wide_data;
  logic [3:0] skip_last;
  logic [7:0] op_now;

  assign wide_data = qpi_cmd || kind_burst;
  assign skip_last = four_byte_addr ? `RLWC_SKIP_NIB_4B : `RLWC_SKIP_NIB_3B;
  assign op_now = rlwc_shift(shreg, io_s, qpi_cmd);

  // next values of the serial decoder and stored settings
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_qpi_cmd = qpi_cmd;
    next_kind_burst = kind_burst;
    next_pend = pend;
    next_pend_val = pend_val;
    next_cfg = cfg;
    if (!sel) begin
      // a frame cut before its last data bit leaves pend low
      // commit only at frame end
      if (pend) begin
        if (kind_burst) begin
          next_cfg.spi_burst_bits = pend_val[6:4];
        end else if (qpi_cmd) begin
          next_cfg.read_parameter = pend_val;
        end else begin
          next_cfg.read_parameter[`RLWC_DUMMY_HI:`RLWC_DUMMY_LO] =
            pend_val[`RLWC_DUMMY_HI:`RLWC_DUMMY_LO];
        end
      end
      next_pend = 1'b0;
      next_state = RLWC_IDLE;
    end else begin
      unique case (state)
        RLWC_IDLE: begin
          // command lane width is latched for the whole frame; burst frames switch to quad after the opcode
          next_state = RLWC_OPCODE;
          next_cnt = 4'h0;
          next_shreg = 8'h00;
          next_qpi_cmd = four_wire_command_mode;
          next_kind_burst = 1'b0;
        end
        RLWC_OPCODE: begin
          if (sclk_rise) begin
            next_shreg = op_now;
            next_cnt = cnt + 4'h1;
            if (cnt == rlwc_last(qpi_cmd)) begin
              next_cnt = 4'h0;
              if (op_now == `RLWC_OP_SET_PARAM) begin
                next_state = RLWC_DATA;
              end else if (op_now == `RLWC_OP_SET_BURST && !qpi_cmd) begin
                // burst bits follow a quad address slot
                next_kind_burst = 1'b1;
                next_state = RLWC_SKIP;
              end else begin
                next_state = RLWC_DONE;
              end
            end
          end
        end
        RLWC_SKIP: begin
          // address slot of the burst frame carries nothing we keep
          if (sclk_rise) begin
            next_cnt = cnt + 4'h1;
            if (cnt == skip_last) begin
              next_cnt = 4'h0;
              next_state = RLWC_DATA;
            end
          end
        end
        RLWC_DATA: begin
          if (sclk_rise) begin
            next_shreg = rlwc_shift(shreg, io_s, wide_data);
            next_cnt = cnt + 4'h1;
            if (cnt == rlwc_last(wide_data)) begin
              next_pend = 1'b1;
              next_pend_val = rlwc_shift(shreg, io_s, wide_data);
              next_state = RLWC_DONE;
            end
          end
        end
        RLWC_DONE: begin
          // remaining clocks of the frame are ignored
          next_state = RLWC_DONE;
        end
        // unused state codes wait quietly for the frame to end
        default: begin
          next_state = RLWC_DONE;
        end
      endcase
    end
    // applied last so it wins over a commit in the same cycle
    // soft reset restores both settings to their reset values, drops pend and parks the decoder
    if (soft_reset) begin
      next_cfg.read_parameter = `RLWC_PARAM_RESET;
      next_cfg.spi_burst_bits = `RLWC_BURST_RESET;
      next_pend = 1'b0;
      next_state = sel ? RLWC_DONE : RLWC_IDLE;
    end
  end

  // register the decoder; a mode switch never touches cfg
  // settings kept across modes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RLWC_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      qpi_cmd <= 1'b0;
      kind_burst <= 1'b0;
      pend <= 1'b0;
      pend_val <= 8'h00;
      cfg.read_parameter <= `RLWC_PARAM_RESET;
      cfg.spi_burst_bits <= `RLWC_BURST_RESET;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      qpi_cmd <= next_qpi_cmd;
      kind_burst <= next_kind_burst;
      pend <= next_pend;
      pend_val <= next_pend_val;
      cfg <= next_cfg;
    end
  end

  // lookup of latency and wrap for the queried opcode
  rlwc_lat_t lat;
  logic [31:0] lat_next_addr;

  rlwc_lat u_lat (
    .cfg(cfg),
    .four_wire_command_mode(four_wire_command_mode),
    .opcode(rd_opcode),
    .addr(rd_addr),
    .lat(lat),
    .next_addr(lat_next_addr)
  );

  // registered answer, one cycle after the query
  // the lookup is combinational; the flop keeps it off the read path timing
  rlwc_lat_t next_ans;
  rlwc_lat_t ans;
  logic [31:0] next_ans_addr;
  logic [31:0] ans_addr;

  always_comb begin
    next_ans = lat;
    next_ans_addr = lat_next_addr;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ans <= '0;
      ans_addr <= 32'h0;
    end else begin
      ans <= next_ans;
      ans_addr <= next_ans_addr;
    end
  end

  // outputs
  assign rd_dummy = ans.dummy;
  assign rd_mode_in_dummy = ans.mode_in_dummy;
  assign rd_configurable = ans.configurable;
  assign rd_wrap_en = ans.wrap_en;
  assign rd_wrap_bytes = ans.wrap_bytes;
  assign rd_next_addr = ans_addr;
  assign read_parameter = cfg.read_parameter;
  assign spi_burst_bits = cfg.spi_burst_bits;

endmodule // rlwc_top
`default_nettype wire

/* File: hw/rlwc_defs.svh */
// constants for the read latency and wrap configuration block
`ifndef RLWC_DEFS_SVH
`define RLWC_DEFS_SVH

// command opcodes
`define RLWC_OP_SET_PARAM 8'hc0
`define RLWC_OP_SET_BURST 8'h77
`define RLWC_OP_FAST_READ 8'h0b
`define RLWC_OP_QIO_READ 8'heb
`define RLWC_OP_QIO_READ4 8'hec
`define RLWC_OP_WRAP_READ 8'h0c
`define RLWC_OP_DDR_FAST_READ 8'h0d
`define RLWC_OP_DDR_QIO_READ 8'hed
`define RLWC_OP_DDR_WRAP_READ 8'h0e

// field positions in the read parameter byte
`define RLWC_DUMMY_HI 6
`define RLWC_DUMMY_LO 4
`define RLWC_WRAP_HI 1
`define RLWC_WRAP_LO 0

// reset values
`define RLWC_PARAM_RESET 8'h00
`define RLWC_BURST_RESET 3'h1

// dummy cycle figures and wrap base length in bytes
`define RLWC_SPI_MIN_DUMMY 5'h06
`define RLWC_DDR_MIN_DUMMY 5'h08
`define RLWC_FIXED_DUMMY 5'h08
`define RLWC_WRAP_BASE_BYTES 7'h08

// serial framing counts (last clock edge index, one less than the edges)
`define RLWC_OP_EDGES_SPI 4'h7
`define RLWC_OP_EDGES_QPI 4'h1
`define RLWC_SKIP_NIB_3B 4'h5
`define RLWC_SKIP_NIB_4B 4'h7

`endif

/* File: hw/rlwc_pkg.sv */
// types shared by the read latency and wrap configuration block
package rlwc_pkg;

  // stored configuration: read parameter byte and burst wrap bits
  typedef struct packed {
    logic [7:0] read_parameter;
    logic [2:0] spi_burst_bits;
  } rlwc_cfg_t;

  // latency and wrap answer for one read opcode
  typedef struct packed {
    logic [4:0] dummy;
    logic mode_in_dummy;
    logic configurable;
    logic wrap_en;
    logic [6:0] wrap_bytes;
  } rlwc_lat_t;

  // serial command decoder states
  typedef enum logic [2:0] {
    RLWC_IDLE,
    RLWC_OPCODE,
    RLWC_SKIP,
    RLWC_DATA,
    RLWC_DONE
  } rlwc_state_t;

endpackage

/* File: hw/rlwc_lat.sv */
// latency and wrap lookup for the configurable read opcodes
`timescale 1ns/1ns
`default_nettype none
`include "rlwc_defs.svh"

module rlwc_lat import rlwc_pkg::*; (
  // configuration and request
  input wire rlwc_cfg_t cfg,
  input wire logic four_wire_command_mode,
  input wire logic [7:0] opcode,
  input wire logic [31:0] addr,
  // answer
  output rlwc_lat_t lat,
  output logic [31:0] next_addr
);

  // dummy count for codes above the floor: two per step plus two
  function automatic logic [4:0] rlwc_scaled(input logic [2:0] code, input logic [4:0] floor);
    logic [4:0] v;
    v = {1'b0, code, 1'b0} + 5'h02;
    rlwc_scaled = (v < floor) ? floor : v;
  endfunction

  // wrap length in bytes from a two bit code
  function automatic logic [6:0] rlwc_bytes(input logic [1:0] code);
    rlwc_bytes = `RLWC_WRAP_BASE_BYTES << code;
  endfunction

  logic [2:0] code;
  logic [6:0] mask;

  assign code = cfg.read_parameter[`RLWC_DUMMY_HI:`RLWC_DUMMY_LO];
  assign mask = lat.wrap_bytes - 7'h01;

  // opcode and mode select the latency table and wrap source
  always_comb begin
    lat = '0;
    lat.dummy = `RLWC_FIXED_DUMMY;
    if (four_wire_command_mode) begin
      unique case (opcode)
        `RLWC_OP_FAST_READ, `RLWC_OP_QIO_READ, `RLWC_OP_WRAP_READ: begin
          lat.configurable = 1'b1;
          lat.dummy = rlwc_scaled(code, 5'h02);
        end
        `RLWC_OP_DDR_FAST_READ, `RLWC_OP_DDR_QIO_READ, `RLWC_OP_DDR_WRAP_READ: begin
          lat.configurable = 1'b1;
          lat.dummy = rlwc_scaled(code, `RLWC_DDR_MIN_DUMMY);
        end
        default: lat.configurable = 1'b0;
      endcase
      lat.mode_in_dummy = (opcode == `RLWC_OP_DDR_QIO_READ);
      lat.wrap_en = (opcode == `RLWC_OP_WRAP_READ) || (opcode == `RLWC_OP_DDR_WRAP_READ);
      lat.wrap_bytes = rlwc_bytes(cfg.read_parameter[`RLWC_WRAP_HI:`RLWC_WRAP_LO]);
    end else begin
      unique case (opcode)
        `RLWC_OP_QIO_READ, `RLWC_OP_QIO_READ4: begin
          lat.configurable = 1'b1;
          lat.dummy = rlwc_scaled(code, `RLWC_SPI_MIN_DUMMY);
        end
        `RLWC_OP_DDR_QIO_READ: begin
          lat.configurable = 1'b1;
          lat.dummy = rlwc_scaled(code, `RLWC_DDR_MIN_DUMMY);
        end
        default: lat.configurable = 1'b0;
      endcase
      // wrap from burst bits, low bit disables
      lat.wrap_en = lat.configurable && !cfg.spi_burst_bits[0];
      lat.wrap_bytes = rlwc_bytes(cfg.spi_burst_bits[2:1]);
    end
  end

  always_comb begin
    if (lat.wrap_en) begin
      next_addr = (addr & ~{25'h0, mask}) | ((addr + 32'h1) & {25'h0, mask});
    end else begin
      next_addr = addr + 32'h1;
    end
  end

endmodule // rlwc_lat
`default_nettype wire

/* File: verif/rlwc_props_properties.sv */
// concurrent checks on the ports of the configuration block
`timescale 1ns/1ns
`default_nettype none

module rlwc_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  // mode and reset request
  input wire logic four_wire_command_mode,
  input wire logic four_byte_addr,
  input wire logic soft_reset,
  // query
  input wire logic [7:0] rd_opcode,
  input wire logic [31:0] rd_addr,
  // answer and stored state
  input wire logic [4:0] rd_dummy,
  input wire logic rd_mode_in_dummy,
  input wire logic rd_configurable,
  input wire logic rd_wrap_en,
  input wire logic [6:0] rd_wrap_bytes,
  input wire logic [31:0] rd_next_addr,
  input wire logic [7:0] read_parameter,
  input wire logic [2:0] spi_burst_bits
);
  logic [2:0] rs;
  logic [2:0] pd;
  logic [1:0] pw;
  logic pb;
  logic [4:0] lin;
  // answers only count once the reset synchroniser has let go
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) rs <= 3'h0;
    else rs <= {rs[1:0], 1'b1};
  end
  // stored fields as the lookup saw them one edge ago
  always_ff @(posedge sys_clk) begin
    pd <= read_parameter[6:4];
    pw <= read_parameter[1:0];
    pb <= spi_burst_bits[0];
  end
  assign lin = {1'b0, pd, 1'b0} + 5'h02;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // frame held open long enough that any earlier commit has landed
  sequence s_open;
    !cs_n [*8];
  endsequence
  AST_RESET_CLEAR: assert property (disable iff (1'b0) !nrst |-> read_parameter == 8'h00)
    else $error("parameter not cleared in reset");
  AST_SOFT_CLEAR: assert property (soft_reset |=> read_parameter == 8'h00 && spi_burst_bits == 3'h1)
    else $error("soft reset did not clear settings");
  AST_FRAME_HOLD: assert property (s_open ##0 !$past(soft_reset) |-> $stable(read_parameter))
    else $error("parameter changed inside a frame");
  AST_QPI_DUMMY: assert property (rs[2] && four_wire_command_mode && rd_opcode inside {8'h0b, 8'heb, 8'h0c}
    |=> rd_dummy == lin && rd_configurable) else $error("four wire latency wrong");
  AST_SPI_DUMMY: assert property (rs[2] && !four_wire_command_mode && rd_opcode inside {8'heb, 8'hec}
    |=> rd_dummy == (pd < 3'h3 ? 5'h06 : lin)) else $error("single wire latency wrong");
  AST_DDR_DUMMY: assert property (rs[2] && (rd_opcode == 8'hed || four_wire_command_mode &&
    rd_opcode inside {8'h0d, 8'h0e}) |=> rd_dummy == (pd < 3'h4 ? 5'h08 : lin))
    else $error("double rate latency wrong");
  AST_MODE_BITS: assert property (rs[2] && rd_opcode == 8'hed
    |=> rd_mode_in_dummy == $past(four_wire_command_mode)) else $error("mode bit flag wrong");
  AST_FIXED: assert property (rs[2] && !(rd_opcode inside {8'h0b, 8'heb, 8'hec, 8'h0c, 8'h0d, 8'hed, 8'h0e})
    |=> !rd_configurable && rd_dummy == 5'h08) else $error("fixed latency wrong");
  AST_QPI_WRAP: assert property (rs[2] && four_wire_command_mode && rd_opcode inside {8'h0c, 8'h0e}
    |=> rd_wrap_en && rd_wrap_bytes == 7'h08 << pw) else $error("wrap length wrong");
  AST_LINEAR: assert property (rs[2] && four_wire_command_mode && rd_opcode inside {8'h0b, 8'heb, 8'hed, 8'h0d}
    |=> !rd_wrap_en) else $error("linear read wraps");
  AST_SPI_WRAP: assert property (rs[2] && !four_wire_command_mode && rd_opcode inside {8'heb, 8'hed}
    |=> rd_wrap_en == !pb) else $error("single wire wrap enable wrong");
  AST_WRAP_SECTION: assert property (rs[2] && four_wire_command_mode && rd_opcode == 8'h0c
    |=> rd_next_addr[31:6] == $past(rd_addr[31:6])) else $error("wrap left its section");
endmodule // rlwc_props

bind rlwc_top rlwc_props chk (.sys_clk, .nrst, .sclk, .cs_n, .io_in, .four_wire_command_mode, .four_byte_addr,
  .soft_reset, .rd_opcode, .rd_addr, .rd_dummy, .rd_mode_in_dummy, .rd_configurable, .rd_wrap_en, .rd_wrap_bytes,
  .rd_next_addr, .read_parameter, .spi_burst_bits);

`default_nettype wire

/* File: verif/rlwc_host.sv */
// host controller model that shifts command frames into the block
`timescale 1ns/1ns
`default_nettype none

module rlwc_host (
  // frame alignment
  input wire logic sys_clk,
  // serial pins toward the block
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io_in
);
  // idle: clock parked low, chip select high
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h5;
  end
  // one 125 ns link clock per unit, data moved while clock low
  task automatic unit(input logic [3:0] v);
    io_in <= v;
    #62;
    sclk <= 1'b1;
    #63;
    sclk <= 1'b0;
  endtask
  task automatic send(input logic opq, input logic [7:0] op, input int skip, input logic dq,
    input logic [7:0] d, input int n);
    int i;
    @(posedge sys_clk);
    cs_n <= 1'b0;
    for (i = 0; i < (opq ? 2 : 8); i++) unit(opq ? op[7 - 4 * i -: 4] : {{3{~op[7 - i]}}, op[7 - i]});
    for (i = 0; i < skip; i++) unit(4'($urandom));
    for (i = 0; i < n; i++) unit(dq ? d[7 - 4 * i -: 4] : {{3{~d[7 - i]}}, d[7 - i]});
    #62;
    // released lines show the inverse, never the last value
    cs_n <= 1'b1;
    io_in <= ~io_in;
  endtask
endmodule // rlwc_host

`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench for the read latency and wrap configuration block
`timescale 1ns/1ns
`default_nettype none

module tb_top import rlwc_pkg::*;;
  logic sys_clk = 1'b0;
  logic nrst = 1'b1;
  logic soft_reset = 1'b0;
  logic four_wire_command_mode = 1'b0;
  logic four_byte_addr = 1'b0;
  logic [7:0] rd_opcode = 8'h00;
  logic [31:0] rd_addr = 32'h0;
  wire sclk;
  wire cs_n;
  wire [3:0] io_in;
  logic [4:0] rd_dummy;
  logic rd_mode_in_dummy;
  logic rd_configurable;
  logic rd_wrap_en;
  logic [6:0] rd_wrap_bytes;
  logic [31:0] rd_next_addr;
  logic [7:0] read_parameter;
  logic [2:0] spi_burst_bits;
  logic [7:0] m_par = 8'h00;
  logic [2:0] m_bur = 3'h1;
  logic look = 1'b0;
  logic look_d = 1'b0;
  logic [57:0] exq[$];
  logic [57:0] seen;
  logic [7:0] ops [10] = '{8'h0b, 8'heb, 8'hec, 8'h0c, 8'h0d, 8'hed, 8'h0e, 8'h03, 8'hbb, 8'h6b};
  int bad_count = 0;
  int checks_done = 0;

  // clock
  initial forever #5 sys_clk = ~sys_clk;

  rlwc_top uut (.sys_clk, .nrst, .sclk, .cs_n, .io_in, .four_wire_command_mode, .four_byte_addr, .soft_reset,
    .rd_opcode, .rd_addr, .rd_dummy, .rd_mode_in_dummy, .rd_configurable, .rd_wrap_en, .rd_wrap_bytes,
    .rd_next_addr, .read_parameter, .spi_burst_bits);
  rlwc_host host (.sys_clk, .sclk, .cs_n, .io_in);

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [57:0] got, input logic [57:0] want);
    checks_done++;
    if (got !== want) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, got, want);
    end
  endtask

  function automatic logic [57:0] want_of(input logic [7:0] op, input logic qm, input logic [31:0] a);
    rlwc_lat_t l;
    logic [4:0] lin;
    logic [31:0] m;
    l = '0;
    l.dummy = 5'h08;
    lin = {1'b0, m_par[6:4], 1'b0} + 5'h02;
    if (!qm && (op inside {8'heb, 8'hec})) l.dummy = m_par[6:4] < 3'h3 ? 5'h06 : lin;
    if (qm && (op inside {8'h0b, 8'heb, 8'h0c})) l.dummy = lin;
    if (op == 8'hed || qm && (op inside {8'h0d, 8'h0e})) l.dummy = m_par[6:4] < 3'h4 ? 5'h08 : lin;
    l.configurable = qm ? (op inside {8'h0b, 8'heb, 8'h0c, 8'h0d, 8'hed, 8'h0e}) : (op inside {8'heb, 8'hec, 8'hed});
    l.mode_in_dummy = qm && op == 8'hed;
    if (qm && (op inside {8'h0c, 8'h0e})) l.wrap_bytes = 7'h08 << m_par[1:0];
    if (!qm && !m_bur[0] && (op inside {8'heb, 8'hec, 8'hed})) l.wrap_bytes = 7'h08 << m_bur[2:1];
    l.wrap_en = l.wrap_bytes != 7'h00;
    m = l.wrap_en ? {25'h0, l.wrap_bytes - 7'h01} : 32'hffffffff;
    return {l, (a & ~m) | ((a + 32'h1) & m), m_par, m_bur};
  endfunction

  // one query; its answer is compared two edges later
  task automatic query(input logic [7:0] op, input logic qm);
    logic [31:0] a;
    a = $urandom;
    @(posedge sys_clk);
    rd_opcode <= op;
    four_wire_command_mode <= qm;
    rd_addr <= a;
    look <= 1'b1;
    exq.push_back(want_of(op, qm, a));
    @(posedge sys_clk);
    look <= 1'b0;
  endtask

  task automatic sweep();
    int i;
    for (i = 0; i < 20; i++) query(ops[i % 10], i >= 10);
  endtask

  task automatic load(input logic qm, input logic [7:0] op, input logic [7:0] d, input int n);
    logic fb;
    logic dq;
    // alternate so both address widths reach the burst frames
    fb = ~four_byte_addr;
    dq = qm || op == 8'h77;
    @(posedge sys_clk);
    four_wire_command_mode <= qm;
    four_byte_addr <= fb;
    host.send(qm, op, (op == 8'h77 && !qm) ? (fb ? 8 : 6) : 0, dq, d, n);
    repeat (8) @(posedge sys_clk);
    if (n == (dq ? 2 : 8) && op == 8'hc0) m_par = qm ? d : {m_par[7], d[6:4], m_par[3:0]};
    if (n == 2 && op == 8'h77 && !qm) m_bur = d[6:4];
  endtask

  // answers and stored state against the oldest note
  assign seen = {rd_dummy, rd_mode_in_dummy, rd_configurable, rd_wrap_en, rd_wrap_en ? rd_wrap_bytes : 7'h00,
    rd_next_addr, read_parameter, spi_burst_bits};
  always @(posedge sys_clk) begin
    look_d <= look;
    if (look_d) check(seen, exq.pop_front());
  end

  // watchdog sized well past the expected run
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    complete_run();
  end

  initial begin
    int c;
    void'($urandom(18772));
    nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    sweep();
    $display("test reset values done");
    for (c = 0; c < 8; c++) begin
      load(1'b0, 8'hc0, {1'($urandom), 3'(c), 4'($urandom)}, 8);
      sweep();
    end
    $display("test dummy codes done");
    for (c = 0; c < 4; c++) begin
      load(1'b1, 8'hc0, {6'($urandom), 2'(c)}, 2);
      sweep();
    end
    $display("test wrap codes done");
    // short frames, foreign opcode and four wire burst load commit nothing
    load(1'b1, 8'hc0, 8'h00, 1);
    load(1'b0, 8'hc0, 8'h00, 7);
    load(1'b0, 8'h9f, 8'h00, 8);
    load(1'b1, 8'h77, 8'h00, 2);
    sweep();
    $display("test refused frames done");
    // burst bits, ending with wrap enabled
    for (c = 4; c >= 0; c--) begin
      load(1'b0, 8'h77, {1'($urandom), 2'(c), c == 4, 4'($urandom)}, 2);
      sweep();
    end
    $display("test burst bits done");
    // soft reset, then a second hard reset
    @(posedge sys_clk);
    soft_reset <= 1'b1;
    @(posedge sys_clk);
    soft_reset <= 1'b0;
    m_par = 8'h00;
    m_bur = 3'h1;
    sweep();
    load(1'b1, 8'hc0, 8'h73, 2);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    m_par = 8'h00;
    sweep();
    $display("test resets done");
    complete_run();
  end
endmodule // tb_top

`default_nettype wire
